// >>> hdl/mpb_pkg.sv
// Operation
// - Run bit starts/idles; period loads on run rise or load-enabled match/underflow.
// - Duty buffers reach active compares on run rise, or with load and run at match/underflow.
// - Compare above reload value keeps generator output permanently high.
// - Compare 0x0000 holds output low; 0xFFFF holds it high.
// - Debug/programming mode tri-states pins, stops and resets the unit; code resets only control, counter, active period/compares and brakes.
// - Debug halt of processor tri-states outputs until processor runs again.
// - Comparator invert turns duty into off time.
// - Period and duty registers are 16-bit, double buffered.
// - Edge mode counts zero to period, restarts; period is value plus one.
// - Output high while counter at or below duty, low above.
// - Period and edge flags set only when their enables are set.
// - Edge mode: new values apply at next period start when load set.
// - Center mode counts up to period then down to zero.
// - Center mode: new values apply at underflow when load set.
// - Center interrupt at underflow when select is 0, at match when 1.
// - Two detectors: pin plus three comparators; pins pass a digital filter.
// - Detector zero fall sets brake flag zero and lock flag until cleared.
// - Braked pins output brake level, inverted when polarity invert set.
// - Lock holds brake while running; clearing releases at next period.
// - Detector one fall sets flag one; level brake forces while low.
// - Detector one release resumes generator output at next period.
// - Brake detection and forcing act only with detector enable bits.
// - Counter clock is unit clock divided by a configurable prescaler.
package mpb_pkg;
	localparam logic [7:0]  ADDR_CTRL   = 8'h00;
	localparam logic [7:0]  ADDR_PERIOD = 8'h04;
	localparam logic [7:0]  ADDR_DUTY0  = 8'h08;
	localparam logic [7:0]  ADDR_DUTY1  = 8'h0C;
	localparam logic [7:0]  ADDR_DUTY2  = 8'h10;
	localparam logic [7:0]  ADDR_STATUS = 8'h14;
	localparam logic [7:0]  ADDR_EDGEIE = 8'h18;
	localparam logic [7:0]  ADDR_BRAKE  = 8'h1C;
	localparam logic [7:0]  ADDR_PRESC  = 8'h20;
	localparam logic [7:0]  ADDR_COUNT  = 8'h24;
	// Control register fields
	localparam int CTL_CENTER   = 0;
	localparam int CTL_PIE      = 4;
	localparam int CTL_LOAD     = 6;
	localparam int CTL_RUN      = 7;
	localparam int CTL_CSEL     = 8;
	localparam int CTL_INV      = 9;
	localparam int CTL_BK0EN    = 10;
	localparam int CTL_BK1EN    = 11;
	localparam int CTL_FILT_LSB = 20;
	localparam int CTL_LVBK     = 27;
	// Status register fields
	localparam int ST_BRAKE_FLAG_ZERO  = 0;
	localparam int ST_BRAKE_FLAG_ONE  = 1;
	localparam int ST_PIF   = 2;
	localparam int ST_EIF   = 4;
	localparam int ST_LOCK  = 8;
	// Brake register fields: level [5:0], polarity invert [13:8]
	localparam int BRK_POL_LSB = 8;
	localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
	localparam logic [15:0] PERIOD_RST = 16'h0000;
	localparam logic [15:0] CMP_ZERO   = 16'h0000;
	localparam logic [15:0] CMP_FULL   = 16'hFFFF;
	localparam logic [1:0]  RESP_OKAY  = 2'b00;
	localparam logic [1:0]  RESP_SLVERR = 2'b10;
	typedef enum logic [1:0] {MPB_RD_IDLE, MPB_RD_VALID} mpb_rd_t;
endpackage

// >>> hdl/mpb_top.sv
`timescale 1ns/100ps
`default_nettype none
module mpb_top #(
	parameter int CH  = 3,
	parameter int PSW = 8
) (
	input  wire logic         clk_sys,
	input  wire logic         rst_n,
	input  wire logic [7:0]   s_axi_awaddr,
	input  wire logic         s_axi_awvalid,
	output logic              s_axi_awready,
	input  wire logic [31:0]  s_axi_wdata,
	input  wire logic [3:0]   s_axi_wstrb,
	input  wire logic         s_axi_wvalid,
	output logic              s_axi_wready,
	output logic [1:0]        s_axi_bresp,
	output logic              s_axi_bvalid,
	input  wire logic         s_axi_bready,
	input  wire logic [7:0]   s_axi_araddr,
	input  wire logic         s_axi_arvalid,
	output logic              s_axi_arready,
	output logic [31:0]       s_axi_rdata,
	output logic [1:0]        s_axi_rresp,
	output logic              s_axi_rvalid,
	input  wire logic         s_axi_rready,
	input  wire logic         debug_emulation_mode,
	input  wire logic         cpu_halted,
	input  wire logic         external_brake_pin_zero,
	input  wire logic         external_brake_pin_one,
	input  wire logic [2:0]   comparator_out,
	output logic [2*CH-1:0]   pwm_out,
	output logic [2*CH-1:0]   pwm_oe_n
);
	logic [31:0]     ctrl_r;
	logic [15:0]     period_buf_r, period_act_r;
	logic [15:0]     duty_buf_r [CH];
	logic [15:0]     duty_act_r [CH];
	logic [15:0]     cnt_r;
	logic            down_r, run_d_r;
	logic [PSW-1:0]  presc_r, pdiv_r;
	logic [2*CH-1:0] brk_lvl_r, brk_pol_r;
	logic [CH-1:0]   edge_ie_r, edge_if_r, gen_prev_r;
	logic            brake_flag_zero_r, brake_flag_one_r, lock_r, pif_r, brake0_act_r, brake1_act_r;
	logic [15:0]     filt0_r, filt1_r;
	logic            pin0_r, pin1_r, src0_d_r, src1_d_r;
	logic [CH-1:0]   gen;
	logic            tick, period_end, bnd, reload, off_mode;
	logic            src0, src1, fall0, fall1;
	logic [3:0]      filt_n;
	logic            aw_hold_r, w_hold_r;
	logic [7:0]      awaddr_r;
	logic [31:0]     wdata_r;
	logic [3:0]      wstrb_r;
	mpb_pkg::mpb_rd_t rd_st_r;
	logic            st_clr, pset;
	logic            wr_go;
	logic [31:0]     wmask;
	logic [31:0]     rd_mux;

	assign off_mode = debug_emulation_mode;
	assign tick = ctrl_r[mpb_pkg::CTL_RUN] && (pdiv_r == presc_r);
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			pdiv_r <= '0;
		else if (off_mode || !ctrl_r[mpb_pkg::CTL_RUN] || tick)
			pdiv_r <= '0;
		else
			pdiv_r <= pdiv_r + 1'b1;
	end

	// Boundary events: edge top, center top (match) and center underflow
	assign period_end = tick && (ctrl_r[mpb_pkg::CTL_CENTER] ?
		(down_r && cnt_r <= 16'h0001) : (cnt_r >= period_act_r));
	assign bnd    = tick && (cnt_r >= period_act_r || (down_r && cnt_r <= 16'h0001));
	assign reload = period_end && ctrl_r[mpb_pkg::CTL_LOAD];

	// counter: edge restarts at zero, center bounces
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r   <= '0;
			down_r  <= 1'b0;
			run_d_r <= 1'b0;
		end else if (off_mode) begin
			cnt_r   <= '0;
			down_r  <= 1'b0;
			run_d_r <= 1'b0;
		end else begin
			run_d_r <= ctrl_r[mpb_pkg::CTL_RUN];
			// run rise starts the count afresh
			if (ctrl_r[mpb_pkg::CTL_RUN] && !run_d_r) begin
				cnt_r  <= '0;
				down_r <= 1'b0;
			end else if (tick) begin
				if (!ctrl_r[mpb_pkg::CTL_CENTER]) begin
					down_r <= 1'b0;
					cnt_r  <= (cnt_r >= period_act_r) ? 16'h0000 : cnt_r + 16'h0001;
				end else if (!down_r) begin
					down_r <= (cnt_r + 16'h0001 >= period_act_r);
					cnt_r  <= (cnt_r >= period_act_r) ? cnt_r - 16'h0001 : cnt_r + 16'h0001;
				end else begin
					down_r <= (cnt_r > 16'h0001);
					cnt_r  <= (cnt_r == 16'h0000) ? 16'h0000 : cnt_r - 16'h0001;
				end
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			period_act_r <= mpb_pkg::PERIOD_RST;
			for (int i = 0; i < CH; i++)
				duty_act_r[i] <= mpb_pkg::CMP_ZERO;
		end else if (off_mode) begin
			period_act_r <= mpb_pkg::PERIOD_RST;
			for (int i = 0; i < CH; i++)
				duty_act_r[i] <= mpb_pkg::CMP_ZERO;
		end else if ((ctrl_r[mpb_pkg::CTL_RUN] && !run_d_r) || reload) begin
			period_act_r <= period_buf_r;
			for (int i = 0; i < CH; i++)
				duty_act_r[i] <= duty_buf_r[i];
		end
	end

	always_comb begin
		for (int i = 0; i < CH; i++) begin
			if (duty_act_r[i] == mpb_pkg::CMP_ZERO)
				gen[i] = 1'b0;
			else if (duty_act_r[i] == mpb_pkg::CMP_FULL || duty_act_r[i] > period_act_r)
				gen[i] = 1'b1;
			else
				gen[i] = ctrl_r[mpb_pkg::CTL_RUN] && (cnt_r <= duty_act_r[i]);
			if (ctrl_r[mpb_pkg::CTL_INV])
				gen[i] = !gen[i];
		end
	end

	// filter length from setting, 1..16 samples
	assign filt_n = ctrl_r[mpb_pkg::CTL_FILT_LSB +: 4];
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			filt0_r <= 16'hFFFF;
			filt1_r <= 16'hFFFF;
			pin0_r  <= 1'b1;
			pin1_r  <= 1'b1;
		end else begin
			filt0_r <= {filt0_r[14:0], external_brake_pin_zero};
			filt1_r <= {filt1_r[14:0], external_brake_pin_one};
			if (&(filt0_r | ~(16'hFFFF >> (4'hF - filt_n))))
				pin0_r <= 1'b1;
			else if (~|(filt0_r & (16'hFFFF >> (4'hF - filt_n))))
				pin0_r <= 1'b0;
			if (&(filt1_r | ~(16'hFFFF >> (4'hF - filt_n))))
				pin1_r <= 1'b1;
			else if (~|(filt1_r & (16'hFFFF >> (4'hF - filt_n))))
				pin1_r <= 1'b0;
		end
	end

	// sources combine: any low source is a brake (comparators active low)
	assign src0  = pin0_r && (&comparator_out);
	assign src1  = pin1_r && (&comparator_out);
	assign fall0 = ctrl_r[mpb_pkg::CTL_BK0EN] && src0_d_r && !src0;
	assign fall1 = ctrl_r[mpb_pkg::CTL_BK1EN] && src1_d_r && !src1;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			src0_d_r <= 1'b1;
			src1_d_r <= 1'b1;
		end else begin
			src0_d_r <= src0;
			src1_d_r <= src1;
		end
	end

	// brake application, released at period boundary (brake zero only once unlocked) or when its enable is cleared
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			brake0_act_r <= 1'b0;
			brake1_act_r <= 1'b0;
		end else if (off_mode) begin
			brake0_act_r <= 1'b0;
			brake1_act_r <= 1'b0;
		end else begin
			if (fall0)
				brake0_act_r <= 1'b1;
			else if (!lock_r && ctrl_r[mpb_pkg::CTL_RUN] && bnd)
				brake0_act_r <= 1'b0;
			else if (!ctrl_r[mpb_pkg::CTL_BK0EN])
				brake0_act_r <= 1'b0;
			if (ctrl_r[mpb_pkg::CTL_BK1EN] && ctrl_r[mpb_pkg::CTL_LVBK] && !src1)
				brake1_act_r <= 1'b1;
			else if (bnd || !ctrl_r[mpb_pkg::CTL_BK1EN] || !ctrl_r[mpb_pkg::CTL_LVBK])
				brake1_act_r <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pwm_out  <= '0;
			pwm_oe_n <= '1;
		end else begin
			pwm_oe_n <= (off_mode || cpu_halted) ? '1 : '0;
			for (int i = 0; i < 2*CH; i++) begin
				if (brake0_act_r || brake1_act_r)
					pwm_out[i] <= brk_lvl_r[i] ^ brk_pol_r[i];
				else
					pwm_out[i] <= (i % 2 == 0) ? gen[i/2] ^ brk_pol_r[i] : brk_pol_r[i];
			end
		end
	end

	// AXI write: address and data accepted in either order
	assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
	assign s_axi_wready  = !w_hold_r && !s_axi_bvalid;
	assign wr_go = aw_hold_r && w_hold_r && !s_axi_bvalid;
	always_comb begin
		for (int b = 0; b < 4; b++)
			wmask[8*b +: 8] = {8{wstrb_r[b]}};
	end
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			aw_hold_r    <= 1'b0;
			w_hold_r     <= 1'b0;
			awaddr_r     <= '0;
			wdata_r      <= '0;
			wstrb_r      <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= mpb_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_r <= 1'b1;
				awaddr_r  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_r <= 1'b1;
				wdata_r  <= s_axi_wdata;
				wstrb_r  <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_hold_r    <= 1'b0;
				w_hold_r     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (awaddr_r > mpb_pkg::ADDR_PRESC || awaddr_r[1:0] != 2'b00)
					? mpb_pkg::RESP_SLVERR : mpb_pkg::RESP_OKAY;
			end else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// Writable registers; debug mode returns only control to its reset value
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_r       <= mpb_pkg::CTRL_RST;
			period_buf_r <= mpb_pkg::PERIOD_RST;
			presc_r      <= '0;
			edge_ie_r    <= '0;
			brk_lvl_r    <= '0;
			brk_pol_r    <= '0;
			for (int i = 0; i < CH; i++)
				duty_buf_r[i] <= mpb_pkg::CMP_ZERO;
		end else if (off_mode) begin
			ctrl_r <= mpb_pkg::CTRL_RST;
		end else if (wr_go) begin
			case (awaddr_r)
				mpb_pkg::ADDR_CTRL:   ctrl_r <= (ctrl_r & ~wmask) | (wdata_r & wmask);
				mpb_pkg::ADDR_PERIOD: period_buf_r <= wdata_r[15:0];
				mpb_pkg::ADDR_DUTY0:  duty_buf_r[0] <= wdata_r[15:0];
				mpb_pkg::ADDR_DUTY1:  duty_buf_r[1 % CH] <= wdata_r[15:0];
				mpb_pkg::ADDR_DUTY2:  duty_buf_r[2 % CH] <= wdata_r[15:0];
				mpb_pkg::ADDR_EDGEIE: edge_ie_r <= wdata_r[CH-1:0];
				mpb_pkg::ADDR_BRAKE: begin
					brk_lvl_r <= wdata_r[2*CH-1:0];
					brk_pol_r <= wdata_r[mpb_pkg::BRK_POL_LSB +: 2*CH];
				end
				mpb_pkg::ADDR_PRESC:  presc_r <= wdata_r[PSW-1:0];
				default: ;
			endcase
		end
	end

	// Status clear strobe; the top count is seen while down_r is already set
	assign st_clr = wr_go && awaddr_r == mpb_pkg::ADDR_STATUS;
	// center flag at top match or underflow
	assign pset = ctrl_r[mpb_pkg::CTL_PIE] && tick && (ctrl_r[mpb_pkg::CTL_CENTER] ?
		(ctrl_r[mpb_pkg::CTL_CSEL] ? (cnt_r >= period_act_r) : period_end)
		: period_end);
	// sticky flags; write one clears, set wins
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			brake_flag_zero_r     <= 1'b0;
			brake_flag_one_r     <= 1'b0;
			lock_r     <= 1'b0;
			pif_r      <= 1'b0;
			edge_if_r  <= '0;
			gen_prev_r <= '0;
		end else begin
			gen_prev_r <= gen;
			brake_flag_zero_r <= fall0 || (brake_flag_zero_r && !(st_clr && wdata_r[mpb_pkg::ST_BRAKE_FLAG_ZERO]));
			lock_r <= fall0 || (lock_r && !(st_clr && wdata_r[mpb_pkg::ST_LOCK]));
			brake_flag_one_r <= fall1 || (brake_flag_one_r && !(st_clr && wdata_r[mpb_pkg::ST_BRAKE_FLAG_ONE]));
			pif_r  <= pset || (pif_r && !(st_clr && wdata_r[mpb_pkg::ST_PIF]));
			for (int i = 0; i < CH; i++)
				edge_if_r[i] <= (edge_ie_r[i] && gen[i] != gen_prev_r[i]) ||
					(edge_if_r[i] && !(st_clr && wdata_r[mpb_pkg::ST_EIF + i]));
		end
	end

	// Read mux
	always_comb begin
		rd_mux = '0;
		case (s_axi_araddr)
			mpb_pkg::ADDR_CTRL:   rd_mux = ctrl_r;
			mpb_pkg::ADDR_PERIOD: rd_mux[15:0] = period_buf_r;
			mpb_pkg::ADDR_DUTY0:  rd_mux[15:0] = duty_buf_r[0];
			mpb_pkg::ADDR_DUTY1:  rd_mux[15:0] = duty_buf_r[1 % CH];
			mpb_pkg::ADDR_DUTY2:  rd_mux[15:0] = duty_buf_r[2 % CH];
			mpb_pkg::ADDR_STATUS: begin
				rd_mux[mpb_pkg::ST_BRAKE_FLAG_ZERO] = brake_flag_zero_r;
				rd_mux[mpb_pkg::ST_BRAKE_FLAG_ONE] = brake_flag_one_r;
				rd_mux[mpb_pkg::ST_PIF]  = pif_r;
				rd_mux[mpb_pkg::ST_EIF +: CH] = edge_if_r;
				rd_mux[mpb_pkg::ST_LOCK] = lock_r;
			end
			mpb_pkg::ADDR_EDGEIE: rd_mux[CH-1:0] = edge_ie_r;
			mpb_pkg::ADDR_BRAKE: begin
				rd_mux[2*CH-1:0] = brk_lvl_r;
				rd_mux[mpb_pkg::BRK_POL_LSB +: 2*CH] = brk_pol_r;
			end
			mpb_pkg::ADDR_PRESC:  rd_mux[PSW-1:0] = presc_r;
			mpb_pkg::ADDR_COUNT:  rd_mux[15:0] = cnt_r;
			default: rd_mux = '0;
		endcase
	end

	// AXI read: one-cycle answer after address taken
	assign s_axi_arready = (rd_st_r == mpb_pkg::MPB_RD_IDLE);
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rd_st_r      <= mpb_pkg::MPB_RD_IDLE;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= mpb_pkg::RESP_OKAY;
		end else begin
			case (rd_st_r)
				mpb_pkg::MPB_RD_IDLE: if (s_axi_arvalid) begin
					rd_st_r      <= mpb_pkg::MPB_RD_VALID;
					s_axi_rvalid <= 1'b1;
					s_axi_rdata  <= rd_mux;
					s_axi_rresp  <= (s_axi_araddr > mpb_pkg::ADDR_COUNT ||
						s_axi_araddr[1:0] != 2'b00) ? mpb_pkg::RESP_SLVERR : mpb_pkg::RESP_OKAY;
				end
				mpb_pkg::MPB_RD_VALID: if (s_axi_rready) begin
					rd_st_r      <= mpb_pkg::MPB_RD_IDLE;
					s_axi_rvalid <= 1'b0;
				end
				default: rd_st_r <= mpb_pkg::MPB_RD_IDLE;
			endcase
		end
	end
endmodule // mpb_top
`default_nettype wire

// >>> verif/mpb_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module mpb_monitor #(
	parameter int CH  = 3,
	parameter int PSW = 8
) (
	input wire logic            clk_sys,
	input wire logic            rst_n,
	input wire logic [7:0]      s_axi_awaddr,
	input wire logic            s_axi_awvalid,
	input wire logic            s_axi_awready,
	input wire logic            s_axi_wvalid,
	input wire logic            s_axi_wready,
	input wire logic [1:0]      s_axi_bresp,
	input wire logic            s_axi_bvalid,
	input wire logic            s_axi_bready,
	input wire logic            s_axi_arvalid,
	input wire logic            s_axi_arready,
	input wire logic [31:0]     s_axi_rdata,
	input wire logic            s_axi_rvalid,
	input wire logic            s_axi_rready,
	input wire logic            debug_emulation_mode,
	input wire logic            cpu_halted,
	input wire logic [2*CH-1:0] pwm_oe_n
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// Bus steps: both write halves taken at one edge, a read address taken
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_ar_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	// Both halves held first, the answer is registered one edge later
	a_write_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
		else $error("write response late");
	a_unmapped_err: assert property (s_wr_taken ##0 (s_axi_awaddr > mpb_pkg::ADDR_PRESC)
		|-> ##2 s_axi_bresp == mpb_pkg::RESP_SLVERR) else $error("unmapped write not refused");
	a_resp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken during response");
	a_read_answer: assert property (s_ar_taken |=> s_axi_rvalid)
		else $error("read data late");
	a_read_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken during data");
	a_debug_float: assert property (debug_emulation_mode |=> pwm_oe_n == '1)
		else $error("pins driven in debug");
	a_halt_float: assert property (cpu_halted |=> &pwm_oe_n)
		else $error("pins driven while halted");
	a_pins_return: assert property (!debug_emulation_mode && !cpu_halted |=> pwm_oe_n == '0)
		else $error("pins not driven");
endmodule // mpb_monitor
bind mpb_top mpb_monitor #(.CH(CH), .PSW(PSW)) u_mon (.*);
`default_nettype wire

// >>> verif/mpb_partner.sv
`timescale 1ns/100ps
`default_nettype none
module mpb_partner (
	input wire logic         clk_sys,
	input wire logic [5:0]   pwm_out,
	input wire logic [5:0]   pwm_oe_n,
	input wire logic [4:0]   trips,
	input wire logic         cnt_clear,
	output logic             external_brake_pin_zero,
	output logic             external_brake_pin_one,
	output logic [2:0]       comparator_out,
	output logic [2:0][15:0] on_cnt
);
	// pin and comparator sources
	// Sources pull low to trip; pins idle high through pull-ups
	assign external_brake_pin_zero = !trips[0];
	assign external_brake_pin_one = !trips[1];
	assign comparator_out = ~trips[4:2];
	// Upper switch on-time, only counted while the pin is really driven
	always_ff @(posedge clk_sys) begin
		for (int i = 0; i < 3; i++) begin
			if (cnt_clear)
				on_cnt[i] <= 16'h0000;
			else if (pwm_out[2*i] && !pwm_oe_n[2*i])
				on_cnt[i] <= on_cnt[i] + 16'h0001;
		end
	end
endmodule // mpb_partner
`default_nettype wire

// >>> verif/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
	localparam logic [31:0] RUNL = 32'hC0;
	localparam logic [31:0] FILT = 32'h0030_0000;
	logic clk_sys = 1'b0, rst_n = 1'b0, cnt_clear = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, debug_emulation_mode = 1'b0, cpu_halted = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic external_brake_pin_zero, external_brake_pin_one;
	logic [2:0] comparator_out;
	logic [4:0] trips = 5'h00;
	logic [5:0] pwm_out, pwm_oe_n;
	logic [2:0][15:0] on_cnt;
	int fails = 0, comparisons = 0, per, pr, ps, lvl, pol;
	int du [3];
	mpb_top #(.CH(3), .PSW(8)) dut (.*);
	mpb_partner u_part (.*);
	// Free-running system clock
	always #5 clk_sys = ~clk_sys;
	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic finish_test();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Bus write; the response is accepted a cycle late so it must stand
	task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] er = mpb_pkg::RESP_OKAY);
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		forever begin
			@(posedge clk_sys);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid && s_axi_bready) begin
				chk("bresp", 32'(s_axi_bresp), 32'(er));
				s_axi_bready <= 1'b0;
				break;
			end
			if (s_axi_bvalid) s_axi_bready <= 1'b1;
		end
	endtask
	task automatic rd(logic [7:0] a, output logic [31:0] d, input logic [1:0] er = 2'h0);
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		forever begin
			@(posedge clk_sys);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid && s_axi_rready) begin
				d = s_axi_rdata;
				chk("rresp", 32'(s_axi_rresp), 32'(er));
				s_axi_rready <= 1'b0;
				break;
			end
			if (s_axi_rvalid) s_axi_rready <= 1'b1;
		end
	endtask
	// High clocks per period; zero duty is the low special case
	function automatic int exp_hi(bit ctr, int d, bit inv);
		int n, h;
		n = ctr ? 2 * pr : pr + 1;
		h = d == 0 ? 0 : d >= pr ? n : ctr ? 2 * d + 1 : d + 1;
		return (inv ? n - h : h) * (ps + 1);
	endfunction
	// Stop, fill buffers, restart so the run edge copies them
	task automatic start(bit ctr, bit inv);
		wr(mpb_pkg::ADDR_CTRL, 32'h0);
		wr(mpb_pkg::ADDR_PRESC, 32'(ps));
		wr(mpb_pkg::ADDR_PERIOD, 32'(pr));
		for (int c = 0; c < 3; c++) wr(mpb_pkg::ADDR_DUTY0 + 8'(4 * c), 32'(du[c]));
		wr(mpb_pkg::ADDR_CTRL, RUNL | 32'(ctr) | 32'(inv) << mpb_pkg::CTL_INV);
		per = (ctr ? 2 * pr : pr + 1) * (ps + 1);
	endtask
	// On-time over four whole periods, after two to settle
	task automatic meas(int ch, int hi);
		repeat (2 * per) @(posedge clk_sys);
		cnt_clear <= 1'b1;
		@(posedge clk_sys);
		cnt_clear <= 1'b0;
		repeat (4 * per) @(posedge clk_sys);
		#1;
		chk("on_time", 32'(on_cnt[ch]), 32'(4 * hi));
	endtask
	task automatic pulse(int b, int n);
		@(posedge clk_sys);
		trips[b] <= 1'b1;
		repeat (n) @(posedge clk_sys);
		trips[b] <= 1'b0;
		repeat (8) @(posedge clk_sys);
	endtask
	// Hang guard, about nine times the expected run of some 5.5k clocks
	initial begin
		#500000;
		fails++;
		finish_test();
	end
	initial begin
		rv = $urandom(32'hB364E160);
		repeat (12) @(posedge clk_sys);
		rst_n <= 1'b1;
		rd(mpb_pkg::ADDR_CTRL, rv);
		chk("ctrl_reset", rv, mpb_pkg::CTRL_RST);
		// Only the strobed low byte of control may change
		s_axi_wstrb <= 4'h1;
		wr(mpb_pkg::ADDR_CTRL, 32'hFFFF_FFFF);
		s_axi_wstrb <= 4'hF;
		rd(mpb_pkg::ADDR_CTRL, rv);
		chk("ctrl_strobe", rv, 32'h0000_00FF);
		wr(8'h28, 32'hFFFF_FFFF, mpb_pkg::RESP_SLVERR);
		rd(8'h28, rv, mpb_pkg::RESP_SLVERR);
		wr(mpb_pkg::ADDR_BRAKE, 32'h0);
		// Channel zero takes the special duties, the others random ones
		for (int i = 0; i < 8; i++) begin
			ps = $urandom_range(2);
			pr = $urandom_range(15, 4);
			du[0] = i % 4 == 0 ? 0 : i % 4 == 1 ? 16'hFFFF : i % 4 == 2 ? pr + 3 : $urandom_range(pr - 1, 1);
			du[1] = $urandom_range(pr, 1);
			du[2] = $urandom_range(pr + 2, 1);
			start(i >= 4, i == 7);
			for (int c = 0; c < 3; c++) meas(c, exp_hi(i >= 4, du[c], i == 7));
		end
		// Buffer writes reach the compare only with load set
		ps = 0;
		pr = 9;
		du = '{3, 5, 7};
		for (int m = 0; m < 2; m++) begin
			start(m, 0);
			wr(mpb_pkg::ADDR_CTRL, 32'h80 | 32'(m));
			wr(mpb_pkg::ADDR_DUTY0, 32'h7);
			meas(0, exp_hi(m, 3, 0));
			wr(mpb_pkg::ADDR_CTRL, RUNL | 32'(m));
			meas(0, exp_hi(m, 7, 0));
		end
		// Flags follow their enables, center interrupt at the match point
		for (int k = 0; k < 2; k++) begin
			wr(mpb_pkg::ADDR_EDGEIE, 32'(7 * k));
			wr(mpb_pkg::ADDR_CTRL, RUNL | 32'h111 * 32'(k));
			wr(mpb_pkg::ADDR_STATUS, 32'hFFFF_FFFF);
			repeat (3 * per) @(posedge clk_sys);
			rd(mpb_pkg::ADDR_STATUS, rv);
			chk("irq_flags", rv & 32'h74, 32'h74 * 32'(k));
		end
		// Brake zero: glitch filtered, then lock until cleared
		lvl = $urandom_range(63);
		pol = $urandom_range(63);
		start(0, 0);
		wr(mpb_pkg::ADDR_BRAKE, 32'(pol << 8 | lvl));
		wr(mpb_pkg::ADDR_CTRL, RUNL | FILT);
		pulse(0, 10);
		rd(mpb_pkg::ADDR_STATUS, rv);
		chk("brake_off", rv & 32'h3, 32'h0);
		wr(mpb_pkg::ADDR_CTRL, RUNL | FILT | 32'h400);
		pulse(0, 2);
		rd(mpb_pkg::ADDR_STATUS, rv);
		chk("glitch", rv & 32'h101, 32'h0);
		pulse(0, 10);
		repeat (2 * per) @(posedge clk_sys);
		chk("brake_pins", 32'(pwm_out), 32'(lvl ^ pol));
		rd(mpb_pkg::ADDR_STATUS, rv);
		chk("brake_flags", rv & 32'h101, 32'h101);
		wr(mpb_pkg::ADDR_STATUS, 32'h101);
		meas(0, pol % 2 ? per - 4 : 4);
		pulse(2 + $urandom_range(2), 10);
		rd(mpb_pkg::ADDR_STATUS, rv);
		chk("cmp_brake", rv & 32'h1, 32'h1);
		wr(mpb_pkg::ADDR_STATUS, 32'h103);
		// Brake one forces levels only while its source stays low
		wr(mpb_pkg::ADDR_CTRL, RUNL | FILT | 32'h0800_0800);
		trips[1] <= 1'b1;
		repeat (2 * per) @(posedge clk_sys);
		chk("level_brake", 32'(pwm_out), 32'(lvl ^ pol));
		trips[1] <= 1'b0;
		rd(mpb_pkg::ADDR_STATUS, rv);
		chk("brake_flag1", rv & 32'h2, 32'h2);
		meas(0, pol % 2 ? per - 4 : 4);
		// Halt and debug float the pins; debug also clears control
		cpu_halted <= 1'b1;
		repeat (3) @(posedge clk_sys);
		chk("halt_float", 32'(pwm_oe_n), 32'h3F);
		cpu_halted <= 1'b0;
		debug_emulation_mode <= 1'b1;
		repeat (3) @(posedge clk_sys);
		chk("debug_float", 32'(pwm_oe_n), 32'h3F);
		debug_emulation_mode <= 1'b0;
		repeat (3) @(posedge clk_sys);
		chk("pins_back", 32'(pwm_oe_n), 32'h0);
		rd(mpb_pkg::ADDR_CTRL, rv);
		chk("debug_clear", rv, mpb_pkg::CTRL_RST);
		// Reset in mid-run leaves the counter idle
		start(1, 0);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'b1;
		rd(mpb_pkg::ADDR_COUNT, rv);
		chk("count_idle", rv, 32'h0);
		finish_test();
	end
endmodule // testbench
`default_nettype wire
